// ### hdl/asc_regs.sv
`timescale 1ns/100ps
module asc_regs #(
    parameter int FWD_T1_CYC = asc_pkg::FWD_T1_CYC,  // Flash watchdog 6.9 ms
    parameter int FWD_T2_CYC = asc_pkg::FWD_T2_CYC,  // Flash watchdog 27.5 ms
    parameter int FWD_T3_CYC = asc_pkg::FWD_T3_CYC,  // Flash watchdog 55 ms
    parameter int POR_ON_CYC = asc_pkg::POR_ON_CYC   // Detector on-time
) (
    // Clock and reset
    input  wire logic       CLOCK,
    input  wire logic       SYS_RST,
    // Register port
    input  wire logic [7:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic      [7:0] RDATA,
    // Non-volatile configuration words
    input  wire logic [7:0] CFG_TRIM_WORD,
    input  wire logic [7:0] CFG_HIGH_WORD,
    // Device status inputs
    input  wire asc_pkg::asc_mode_t CPU_MODE,
    input  wire logic       FLASH_WRITE_BUSY,
    input  wire logic       ADC_DONE,
    input  wire logic       FIRST_TIMER_COUNTER_MODE,
    input  wire logic       SECOND_TIMER_COUNTER_MODE,
    input  wire logic       FIRST_TIMER_PIN,
    input  wire logic       SECOND_TIMER_PIN,
    input  wire logic       SLOW_CLOCK_DIV16,
    input  wire logic       EXT_RESET_PIN_N,
    input  wire logic       POR_POWER_DOWN,
    // Control outputs
    output logic      [6:0] RC_FREQ_TRIM,
    output logic            WD_ACTIVE,
    output logic            LOW_POWER_ACTIVE,
    output logic            BANDGAP_PIN_OUT,
    output logic            WIDE_ARITH_SEL,
    output logic            EXTENDED_DIVIDE,
    output logic            WD_CLEAR,
    output logic            THIRD_TIMER_CLEAR,
    output logic            FIRST_PWM_CLEAR,
    output logic            SECOND_PWM_CLEAR,
    output logic            CONVERSION_START,
    output logic            FIRST_TIMER_COUNT_IN,
    output logic            SECOND_TIMER_COUNT_IN,
    output logic            POINTER_SELECT,
    output logic            FLASH_WD_TIMEOUT,
    output logic            CODE_PROTECT,
    output logic            EXT_RESET_REQ,
    output logic            POR_DETECT_EN,
    output logic            IRQ
);

    //------------------------------------------------------------------
    // Storage
    //------------------------------------------------------------------
    logic [6:0]                 trim_r;         // Oscillator trim
    logic [7:0]                 ctl2_r;         // Control two
    logic [7:0]                 ctl1_r;         // Control one
    logic [7:0]                 cfg_hi_r;       // Config high copy
    logic                       load_pend_r;    // Config load pending
    logic [asc_pkg::IRQ_W-1:0]  irq_stat_r;     // Sticky events
    logic [asc_pkg::IRQ_W-1:0]  irq_mask_r;     // Event enables
    logic [asc_pkg::IRQ_W-1:0]  irq_ev;         // Event pulses
    logic [asc_pkg::CNT_W-1:0]  fwd_cnt_r;      // Flash watchdog count
    logic [asc_pkg::CNT_W-1:0]  fwd_lim;        // Selected limit
    logic                       fwd_to_r;       // Flash watchdog expired
    logic                       fwd_hit;        // Expiry this cycle
    logic [asc_pkg::CNT_W-1:0]  por_cnt_r;      // Detector duty count
    logic                       run_mode;       // Fast or slow
    logic                       wr_t2;          // Write control two
    logic                       wr_t1;          // Write control one

    //------------------------------------------------------------------
    // Decode helpers
    //------------------------------------------------------------------
    assign run_mode = (CPU_MODE == asc_pkg::MODE_FAST) || (CPU_MODE == asc_pkg::MODE_SLOW);
    assign wr_t2    = WR && (ADDR == asc_pkg::AUX_CONTROL_TWO_ADDR);
    assign wr_t1    = WR && (ADDR == asc_pkg::AUX_CONTROL_ONE_ADDR);

    //------------------------------------------------------------------
    // Configuration capture and trim register
    //------------------------------------------------------------------
    // Config words are caught on the first edge after reset release
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            load_pend_r <= 1'b1;
            trim_r      <= 7'h00;
            cfg_hi_r    <= 8'h00;
        end else if (load_pend_r) begin
            load_pend_r <= 1'b0;
            trim_r      <= CFG_TRIM_WORD[6:0];
            cfg_hi_r    <= CFG_HIGH_WORD;
        end else if (WR && (ADDR == asc_pkg::OSC_TRIM_WORD_ADDR)) begin
            trim_r      <= WDATA[6:0];
        end
    end

    //------------------------------------------------------------------
    // Control two: plain read/write
    //------------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            ctl2_r <= asc_pkg::CTRL_RST;
        end else if (wr_t2) begin
            ctl2_r <= WDATA;
        end
    end

    //------------------------------------------------------------------
    // Control one: self-clearing strobes, held clears, start bit
    //------------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            ctl1_r <= asc_pkg::CTRL_RST;
        end else begin
            // Strobes drop one cycle after being set
            ctl1_r[asc_pkg::WD_CLR_BIT]  <= wr_t1 && WDATA[asc_pkg::WD_CLR_BIT];
            ctl1_r[asc_pkg::TM3_CLR_BIT] <= wr_t1 && WDATA[asc_pkg::TM3_CLR_BIT];
            if (wr_t1) begin
                ctl1_r[asc_pkg::PWM1_CLR_BIT] <= WDATA[asc_pkg::PWM1_CLR_BIT];
                ctl1_r[asc_pkg::PWM2_CLR_BIT] <= WDATA[asc_pkg::PWM2_CLR_BIT];
                ctl1_r[asc_pkg::T2_SEL_BIT]   <= WDATA[asc_pkg::T2_SEL_BIT];
                ctl1_r[asc_pkg::T1_SEL_BIT]   <= WDATA[asc_pkg::T1_SEL_BIT];
                ctl1_r[asc_pkg::DPTR_BIT]     <= WDATA[asc_pkg::DPTR_BIT];
            end
            // Start bit: a write wins over a done in the same cycle
            if (wr_t1) begin
                ctl1_r[asc_pkg::CONV_BIT] <= WDATA[asc_pkg::CONV_BIT];
            end else if (ADC_DONE) begin
                ctl1_r[asc_pkg::CONV_BIT] <= 1'b0;
            end
        end
    end

    //------------------------------------------------------------------
    // Flash-write watchdog
    //------------------------------------------------------------------
    // Limit from the mode field; zero mode disables
    always_comb begin
        case (ctl2_r[asc_pkg::FWD_HI:asc_pkg::FWD_LO])
            2'h1:    fwd_lim = asc_pkg::CNT_W'(FWD_T1_CYC);
            2'h2:    fwd_lim = asc_pkg::CNT_W'(FWD_T2_CYC);
            2'h3:    fwd_lim = asc_pkg::CNT_W'(FWD_T3_CYC);
            default: fwd_lim = '0;
        endcase
    end

    assign fwd_hit = FLASH_WRITE_BUSY && (fwd_lim != '0) && !fwd_to_r &&
                     (fwd_cnt_r == fwd_lim - 1'b1);

    // Counts while a flash write is busy, flag holds until it ends
    always_ff @(posedge CLOCK) begin
        if (SYS_RST || !FLASH_WRITE_BUSY || (fwd_lim == '0)) begin
            fwd_cnt_r <= '0;
            fwd_to_r  <= 1'b0;
        end else if (fwd_hit) begin
            fwd_to_r  <= 1'b1;
        end else if (!fwd_to_r) begin
            fwd_cnt_r <= fwd_cnt_r + 1'b1;
        end
    end

    //------------------------------------------------------------------
    // Reset detector duty cycle
    //------------------------------------------------------------------
    // Free-running period of eight on-times
    always_ff @(posedge CLOCK) begin
        if (SYS_RST || (por_cnt_r == asc_pkg::CNT_W'(POR_ON_CYC * asc_pkg::POR_DUTY_DIV - 1))) begin
            por_cnt_r <= '0;
        end else begin
            por_cnt_r <= por_cnt_r + 1'b1;
        end
    end

    //------------------------------------------------------------------
    // Interrupt status and mask
    //------------------------------------------------------------------
    always_comb begin
        irq_ev                       = '0;
        irq_ev[asc_pkg::IRQ_FWD_BIT] = fwd_hit;
        irq_ev[asc_pkg::IRQ_ADC_BIT] = ADC_DONE;
    end

    // Write one clears; a new event wins over the clear
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            irq_stat_r <= asc_pkg::IRQ_RST;
        end else if (WR && (ADDR == asc_pkg::IRQ_STATUS_ADDR)) begin
            irq_stat_r <= (irq_stat_r & ~WDATA[asc_pkg::IRQ_W-1:0]) | irq_ev;
        end else begin
            irq_stat_r <= irq_stat_r | irq_ev;
        end
    end

    // Mask register
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            irq_mask_r <= asc_pkg::IRQ_RST;
        end else if (WR && (ADDR == asc_pkg::IRQ_MASK_ADDR)) begin
            irq_mask_r <= WDATA[asc_pkg::IRQ_W-1:0];
        end
    end

    //------------------------------------------------------------------
    // Read port
    //------------------------------------------------------------------
    // Data one cycle after the strobe, zero otherwise and when unmapped
    always_ff @(posedge CLOCK) begin
        if (SYS_RST || !RD) begin
            RDATA <= 8'h00;
        end else if (ADDR == asc_pkg::OSC_TRIM_WORD_ADDR) begin
            RDATA <= {1'b0, trim_r};
        end else if (ADDR == asc_pkg::AUX_CONTROL_TWO_ADDR) begin
            RDATA <= ctl2_r;
        end else if (ADDR == asc_pkg::AUX_CONTROL_ONE_ADDR) begin
            RDATA <= ctl1_r;
        end else if (ADDR == asc_pkg::IRQ_STATUS_ADDR) begin
            RDATA <= {6'h00, irq_stat_r};
        end else if (ADDR == asc_pkg::IRQ_MASK_ADDR) begin
            RDATA <= {6'h00, irq_mask_r};
        end else if (ADDR == asc_pkg::CONFIG_HIGH_ADDR) begin
            RDATA <= {cfg_hi_r[7:5], 5'h00};
        end else begin
            RDATA <= 8'h00;
        end
    end

    //------------------------------------------------------------------
    // Registered control outputs
    //------------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            RC_FREQ_TRIM      <= 7'h00;
            WD_ACTIVE         <= 1'b0;
            LOW_POWER_ACTIVE  <= 1'b0;
            BANDGAP_PIN_OUT   <= 1'b0;
            WIDE_ARITH_SEL    <= 1'b0;
            EXTENDED_DIVIDE   <= 1'b0;
            FIRST_PWM_CLEAR   <= 1'b0;
            SECOND_PWM_CLEAR  <= 1'b0;
            POINTER_SELECT    <= 1'b0;
            FLASH_WD_TIMEOUT  <= 1'b0;
            IRQ               <= 1'b0;
        end else begin
            RC_FREQ_TRIM      <= trim_r;
            // Upper bit off disables; lower bit picks always or run-only
            WD_ACTIVE         <= ctl2_r[asc_pkg::WD_MODE_HI] &&
                                 (ctl2_r[asc_pkg::WD_MODE_LO] || run_mode);
            LOW_POWER_ACTIVE  <= ctl2_r[asc_pkg::PWR_SAVE_BIT] && !run_mode;
            BANDGAP_PIN_OUT   <= ctl2_r[asc_pkg::BANDGAP_BIT];
            WIDE_ARITH_SEL    <= ctl2_r[asc_pkg::WIDE_BIT];
            EXTENDED_DIVIDE   <= ctl2_r[asc_pkg::WIDE_BIT] && ctl2_r[asc_pkg::EXT_DIV_BIT];
            FIRST_PWM_CLEAR   <= ctl1_r[asc_pkg::PWM1_CLR_BIT];
            SECOND_PWM_CLEAR  <= ctl1_r[asc_pkg::PWM2_CLR_BIT];
            POINTER_SELECT    <= ctl1_r[asc_pkg::DPTR_BIT];
            FLASH_WD_TIMEOUT  <= fwd_to_r;
            IRQ               <= |(irq_stat_r & irq_mask_r);
        end
    end

    //------------------------------------------------------------------
    // Strobes, counter sources, config-driven outputs
    //------------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            WD_CLEAR              <= 1'b0;
            THIRD_TIMER_CLEAR     <= 1'b0;
            CONVERSION_START      <= 1'b0;
            FIRST_TIMER_COUNT_IN  <= 1'b0;
            SECOND_TIMER_COUNT_IN <= 1'b0;
            CODE_PROTECT          <= 1'b0;
            EXT_RESET_REQ         <= 1'b0;
            POR_DETECT_EN         <= 1'b1;
        end else begin
            WD_CLEAR          <= wr_t1 && WDATA[asc_pkg::WD_CLR_BIT];
            THIRD_TIMER_CLEAR <= wr_t1 && WDATA[asc_pkg::TM3_CLR_BIT];
            CONVERSION_START  <= wr_t1 && WDATA[asc_pkg::CONV_BIT];
            // Counter input only in counter mode
            FIRST_TIMER_COUNT_IN <= FIRST_TIMER_COUNTER_MODE &&
                (ctl1_r[asc_pkg::T1_SEL_BIT] ? SLOW_CLOCK_DIV16 : FIRST_TIMER_PIN);
            SECOND_TIMER_COUNT_IN <= SECOND_TIMER_COUNTER_MODE &&
                (ctl1_r[asc_pkg::T2_SEL_BIT] ? SLOW_CLOCK_DIV16 : SECOND_TIMER_PIN);
            CODE_PROTECT  <= cfg_hi_r[asc_pkg::CODE_PROTECT_BIT];
            EXT_RESET_REQ <= cfg_hi_r[asc_pkg::XRST_BIT] && !EXT_RESET_PIN_N;
            // Power-down turns the detector off
            POR_DETECT_EN <= !POR_POWER_DOWN && (!cfg_hi_r[asc_pkg::POR_SEL_BIT] ||
                             (por_cnt_r < asc_pkg::CNT_W'(POR_ON_CYC)));
        end
    end

    //------------------------------------------------------------------
    // Checks
    //------------------------------------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);

    a_wd_mode_off: assert property (
        !ctl2_r[asc_pkg::WD_MODE_HI] |=> !WD_ACTIVE)
        else $error("watchdog active with mode off");
    a_wd_mode_run: assert property (
        (ctl2_r[asc_pkg::WD_MODE_HI:asc_pkg::WD_MODE_LO] == 2'h2) && !run_mode |=> !WD_ACTIVE)
        else $error("run-only watchdog active in low power");
    a_save_power: assert property (
        ctl2_r[asc_pkg::PWR_SAVE_BIT] && (CPU_MODE == asc_pkg::MODE_STOP)
        |=> LOW_POWER_ACTIVE)
        else $error("power save not entered");
    a_ext_divide: assert property (
        EXTENDED_DIVIDE |-> $past(ctl2_r[asc_pkg::WIDE_BIT]))
        else $error("extended divide without wide arithmetic");
    a_wd_clear_pulse: assert property (
        wr_t1 && WDATA[asc_pkg::WD_CLR_BIT] |=> WD_CLEAR ##1 !ctl1_r[asc_pkg::WD_CLR_BIT])
        else $error("watchdog clear bit did not self clear");
    a_tm3_clear_pulse: assert property (
        ctl1_r[asc_pkg::TM3_CLR_BIT] && !wr_t1 |=> !ctl1_r[asc_pkg::TM3_CLR_BIT])
        else $error("third timer clear bit stuck");
    a_pwm_hold: assert property (
        (ctl1_r[asc_pkg::PWM1_CLR_BIT] && !wr_t1) [*2] |=> FIRST_PWM_CLEAR)
        else $error("first pwm not held cleared");
    a_conv_done: assert property (
        ADC_DONE && !wr_t1 |=> !ctl1_r[asc_pkg::CONV_BIT])
        else $error("start bit not cleared at conversion end");
    a_fwd_flag: assert property (
        fwd_hit |=> fwd_to_r ##1 FLASH_WD_TIMEOUT || !FLASH_WRITE_BUSY)
        else $error("flash watchdog flag not raised");
    a_irq_sticky: assert property (
        irq_ev != '0 |=> (irq_stat_r & $past(irq_ev)) == $past(irq_ev))
        else $error("event lost from status");
    a_ext_reset: assert property (
        !cfg_hi_r[asc_pkg::XRST_BIT] |=> !EXT_RESET_REQ)
        else $error("external reset while disabled");
    a_por_power_down: assert property (
        POR_POWER_DOWN |=> !POR_DETECT_EN)
        else $error("reset detector on while powered down");
    a_bandgap_route: assert property (
        BANDGAP_PIN_OUT == $past(ctl2_r[asc_pkg::BANDGAP_BIT]))
        else $error("bandgap output does not follow its bit");

    c_conv_start: cover property (wr_t1 && WDATA[asc_pkg::CONV_BIT] ##[1:20] ADC_DONE);
    c_fwd_timeout: cover property (fwd_hit);
    c_irq_raised: cover property (IRQ);
    c_por_duty: cover property (cfg_hi_r[asc_pkg::POR_SEL_BIT] && $fell(POR_DETECT_EN));

endmodule

// ### hdl/asc_pkg.sv
//----------------------------------------------------------------------
//----------------------------------------------------------------------
package asc_pkg;

    //------------------------------------------------------------------
    // Register offsets
    //------------------------------------------------------------------
    localparam logic [7:0] OSC_TRIM_WORD_ADDR   = 8'hf6;  // Trim register
    localparam logic [7:0] AUX_CONTROL_TWO_ADDR = 8'hf7;  // Control two
    localparam logic [7:0] AUX_CONTROL_ONE_ADDR = 8'hf8;  // Control one
    localparam logic [7:0] IRQ_STATUS_ADDR      = 8'hf9;  // Sticky events
    localparam logic [7:0] IRQ_MASK_ADDR        = 8'hfa;  // Event enables
    localparam logic [7:0] CONFIG_HIGH_ADDR     = 8'hfb;  // Config copy, read only

    //------------------------------------------------------------------
    // Field positions, control two
    //------------------------------------------------------------------
    localparam int WD_MODE_HI   = 7;  // Watchdog mode upper bit
    localparam int WD_MODE_LO   = 6;  // Watchdog mode lower bit
    localparam int PWR_SAVE_BIT = 5;  // Power save
    localparam int BANDGAP_BIT  = 4;  // Bandgap output
    localparam int EXT_DIV_BIT  = 3;  // Extended divide
    localparam int FWD_HI       = 2;  // Flash watchdog mode upper
    localparam int FWD_LO       = 1;  // Flash watchdog mode lower
    localparam int WIDE_BIT     = 0;  // Wide arithmetic

    //------------------------------------------------------------------
    // Field positions, control one
    //------------------------------------------------------------------
    localparam int WD_CLR_BIT   = 7;  // Watchdog clear
    localparam int TM3_CLR_BIT  = 6;  // Third timer clear
    localparam int PWM1_CLR_BIT = 5;  // First PWM clear
    localparam int CONV_BIT     = 4;  // Conversion start
    localparam int PWM2_CLR_BIT = 3;  // Second PWM clear
    localparam int T2_SEL_BIT   = 2;  // Second timer source
    localparam int T1_SEL_BIT   = 1;  // First timer source
    localparam int DPTR_BIT     = 0;  // Pointer select

    //------------------------------------------------------------------
    // Config high word and interrupt layout
    //------------------------------------------------------------------
    localparam int CODE_PROTECT_BIT     = 7;  // Code protect
    localparam int XRST_BIT     = 6;  // External reset enable
    localparam int POR_SEL_BIT  = 5;  // Detector duty select
    localparam int IRQ_FWD_BIT  = 0;  // Flash watchdog time-out event
    localparam int IRQ_ADC_BIT  = 1;  // Conversion done event
    localparam int IRQ_W        = 2;  // Event count

    //------------------------------------------------------------------
    // Reset values
    //------------------------------------------------------------------
    localparam logic [7:0]       CTRL_RST = 8'h00;  // Both controls
    localparam logic [IRQ_W-1:0] IRQ_RST  = 2'h0;   // Status and mask

    //------------------------------------------------------------------
    // Timing
    //------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;        // 40 MHz
    localparam int FWD_T1_NS     = 6900000;   // 6.9 ms
    localparam int FWD_T2_NS     = 27500000;  // 27.5 ms
    localparam int FWD_T3_NS     = 55000000;  // 55 ms
    localparam int POR_ON_NS     = 2000000;   // 2 ms
    localparam int POR_DUTY_DIV  = 8;         // One-eighth duty
    localparam int FWD_T1_CYC = (FWD_T1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FWD_T2_CYC = (FWD_T2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FWD_T3_CYC = (FWD_T3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POR_ON_CYC = POR_ON_NS / CLK_PERIOD_NS;
    localparam int CNT_W      = 22;  // Wide enough for longest count

    //------------------------------------------------------------------
    // CPU power modes
    //------------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_FAST,
        MODE_SLOW,
        MODE_IDLE,
        MODE_HALT,
        MODE_STOP
    } asc_mode_t;

endpackage

// ### tb/aux_system_control_regs_test.sv
`timescale 1ns/100ps
module aux_system_control_regs_test;
    //------------------------------------------------------------------
    // Stimulus and observed signals
    //------------------------------------------------------------------
    logic       clock, sys_rst, wr, rd, busy, adc_done, pin_n;
    logic [7:0] addr, wdata, rdata, cfg_trim, cfg_high;
    logic [6:0] trim;
    logic       wd, lowp, bg, wide, ediv, wdc, t3c, p1c, p2c, conv;
    logic       t1in, t2in, psel, fwdto, code_protect, xreq, poren, irq;
    logic       t1cm, t2cm, pin1, pin2, slow, pordn;
    asc_pkg::asc_mode_t mode;
    int         num_errors, samples_checked, cycles, c0, cn;
    // Design with short flash watchdog counts
    asc_regs #(.FWD_T1_CYC(10), .FWD_T2_CYC(20), .FWD_T3_CYC(30), .POR_ON_CYC(4)) uut (
        .CLOCK(clock), .SYS_RST(sys_rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .CFG_TRIM_WORD(cfg_trim), .CFG_HIGH_WORD(cfg_high), .CPU_MODE(mode),
        .FLASH_WRITE_BUSY(busy), .ADC_DONE(adc_done), .FIRST_TIMER_COUNTER_MODE(t1cm),
        .SECOND_TIMER_COUNTER_MODE(t2cm), .FIRST_TIMER_PIN(pin1), .SECOND_TIMER_PIN(pin2),
        .SLOW_CLOCK_DIV16(slow), .EXT_RESET_PIN_N(pin_n), .POR_POWER_DOWN(pordn),
        .RC_FREQ_TRIM(trim), .WD_ACTIVE(wd), .LOW_POWER_ACTIVE(lowp), .BANDGAP_PIN_OUT(bg),
        .WIDE_ARITH_SEL(wide), .EXTENDED_DIVIDE(ediv), .WD_CLEAR(wdc), .THIRD_TIMER_CLEAR(t3c),
        .FIRST_PWM_CLEAR(p1c), .SECOND_PWM_CLEAR(p2c), .CONVERSION_START(conv),
        .FIRST_TIMER_COUNT_IN(t1in), .SECOND_TIMER_COUNT_IN(t2in), .POINTER_SELECT(psel),
        .FLASH_WD_TIMEOUT(fwdto), .CODE_PROTECT(code_protect), .EXT_RESET_REQ(xreq),
        .POR_DETECT_EN(poren), .IRQ(irq));
    //------------------------------------------------------------------
    // Clock and hang guard
    //------------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin  // Ceiling well above run length
            num_errors++;
            summarize();
        end
    end
    //------------------------------------------------------------------
    // Bus tasks and checks
    //------------------------------------------------------------------
    task chk(string n, logic [7:0] e, logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            num_errors++;
        end
    endtask
    task wrb(logic [7:0] a, logic [7:0] d);  // One write cycle
        @(posedge clock);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
        #1;
    endtask
    task rdc(logic [7:0] a, logic [7:0] e);  // Read and compare
        @(posedge clock);
        addr <= a; rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1 chk("rdata", e, rdata);
    endtask
    task settle;  // Let derived outputs follow
        repeat (2) @(posedge clock);
        #1;
    endtask
    task summarize;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    //------------------------------------------------------------------
    // Main sequence
    //------------------------------------------------------------------
    initial begin
        {wr, rd, busy, adc_done, addr, wdata, cycles, num_errors, samples_checked} = '0;
        pin_n = 1'b1; cfg_trim = 8'hd5; cfg_high = 8'he0; mode = asc_pkg::MODE_FAST;
        {t1cm, t2cm, pin1, pin2, slow, pordn} = 6'h3c;
        sys_rst = 1'b1;
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        settle();
        chk("trim", 8'h55, {1'b0, trim}); rdc(8'hf6, 8'h55);
        rdc(8'hf7, 8'h00); rdc(8'hf8, 8'h00); rdc(8'hfb, 8'he0); rdc(8'hf0, 8'h00);
        chk("protect", 8'h01, code_protect);
        chk("xreq idle", 8'h00, xreq);
        @(posedge clock) pin_n <= 1'b0; settle(); chk("xreq", 8'h01, xreq);
        @(posedge clock) pin_n <= 1'b1;
        wrb(8'hf6, 8'h7f); settle(); chk("trim max", 8'h7f, {1'b0, trim});
        // Detector duty, then powered down
        for (int p = 0; p < 2; p++) begin
            @(posedge clock) pordn <= p[0]; cn = 0;
            repeat (32) begin
                @(posedge clock); #1 cn += poren;
            end
            chk("por duty", 8'(4 - 4 * p), 8'(cn));
        end
        @(posedge clock) pordn <= 1'b0;
        // Watchdog mode and power save across CPU modes
        for (int w = 0; w < 4; w++) begin
            for (int m = 0; m < 5; m++) begin
                wrb(8'hf7, {w[1:0], 6'h20});
                @(posedge clock) mode <= asc_pkg::asc_mode_t'(m); settle();
                chk("wd", {7'h0, w[1] & (w[0] | m < 2)}, wd);
                chk("lowp", {7'h0, m >= 2}, lowp);
            end
        end
        wrb(8'hf7, 8'h19); settle(); chk("arith", 8'h07, {bg, wide, ediv});
        wrb(8'hf7, 8'h08); settle(); chk("arith8", 8'h00, {bg, wide, ediv});
        rdc(8'hf7, 8'h08);
        // Self-clearing strobes
        wrb(8'hf8, 8'hc0); chk("strobes", 8'h03, {wdc, t3c});
        @(posedge clock); #1 chk("strobes off", 8'h00, {wdc, t3c});
        rdc(8'hf8, 8'h00);
        // PWM holds and count sources
        wrb(8'hf8, 8'h28); settle(); chk("pwm", 8'h03, {p1c, p2c});
        chk("pins", 8'h03, {t1in, t2in});
        @(posedge clock) {pin1, slow} <= 2'b01; settle(); chk("pin low", 8'h01, {t1in, t2in});
        @(posedge clock) {pin1, slow} <= 2'b10;
        wrb(8'hf8, 8'h07); settle(); chk("slow", 8'h01, {p1c, p2c, t1in, t2in, psel});
        @(posedge clock) {t2cm, slow} <= 2'b01; settle(); chk("cmode", 8'h02, {t1in, t2in});
        // Conversion start, done and interrupt
        wrb(8'hf8, 8'h10); chk("conv", 8'h01, conv); rdc(8'hf8, 8'h10);
        @(posedge clock); adc_done <= 1'b1;
        @(posedge clock); adc_done <= 1'b0;
        rdc(8'hf8, 8'h00); rdc(8'hf9, 8'h02); chk("irq masked", 8'h00, irq);
        wrb(8'hfa, 8'h02); settle(); chk("irq", 8'h01, irq);
        wrb(8'hf9, 8'h02); settle(); chk("irq clr", 8'h00, irq); rdc(8'hf9, 8'h00);
        wrb(8'hf8, 8'h10); wrb(8'hf8, 8'h00); rdc(8'hf8, 8'h00);
        // Flash watchdog timeout lengths
        for (int f = 1; f < 4; f++) begin
            wrb(8'hf7, {5'h0, f[1:0], 1'b0}); @(posedge clock) busy <= 1'b1; cn = 0;
            while (fwdto !== 1'b1 && cn < 100) begin
                @(posedge clock); #1 cn++;
            end
            if (f == 1) c0 = cn;
            chk("fwd span", 8'((f - 1) * 10), 8'(cn - c0));
            if (f == 1) chk("fwd first", 8'h01, {7'h0, cn >= 9 && cn <= 12});
            @(posedge clock) busy <= 1'b0; settle();
        end
        rdc(8'hf9, 8'h01);
        wrb(8'hf7, 8'h00); @(posedge clock) busy <= 1'b1; repeat (40) @(posedge clock);
        #1 chk("fwd off", 8'h00, fwdto);
        // Second reset with other config words
        @(posedge clock) busy <= 1'b0; sys_rst <= 1'b1; {cfg_trim, cfg_high} <= 16'h2a00;
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0; pin_n <= 1'b0; settle();
        chk("trim reload", 8'h2a, {1'b0, trim}); chk("cfg off", 8'h00, {code_protect, xreq});
        chk("por on", 8'h01, poren); rdc(8'hf9, 8'h00); rdc(8'hfb, 8'h00);
        summarize();
    end
endmodule
